// >>> hdl/trim_override_and_block_reset_regs.sv
`timescale 1ns/100ps
`default_nettype none

module trim_override_and_block_reset_regs (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic AMP_FIVE_VOLT_SELECT,
  input wire logic AMP_HIGH_PERF_SELECT,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] CH1_TRIM_INTERNAL,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] CH2_TRIM_INTERNAL,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] CH2_TRIM_LOWPOW_5V,
  input wire logic [trim_regs_pkg::TRIM_W-1:0] CH2_TRIM_HIGHPERF_5V,
  input wire logic [trim_regs_pkg::GATE_W-1:0] MIXER_GATE_INTERNAL,
  input wire logic [trim_regs_pkg::GATE_W-1:0] MIXER_GATE_OVERRIDE,
  input wire logic [trim_regs_pkg::BIAS_W-1:0] IF_LIN_INTERNAL,
  input wire logic [trim_regs_pkg::BIAS_W-1:0] IF_LIN_OVERRIDE,
  input wire logic [trim_regs_pkg::BIAS_W-1:0] IF_MAIN_INTERNAL,
  input wire logic [trim_regs_pkg::BIAS_W-1:0] IF_MAIN_OVERRIDE,
  input wire logic [trim_regs_pkg::LPF_W-1:0] LOWPASS_INTERNAL,
  input wire logic [trim_regs_pkg::LPF_W-1:0] LOWPASS_OVERRIDE,
  output logic [trim_regs_pkg::TRIM_W-1:0] CH1_TRIM,
  output logic [trim_regs_pkg::TRIM_W-1:0] CH2_TRIM,
  output logic [trim_regs_pkg::GATE_W-1:0] MIXER_GATE,
  output logic [trim_regs_pkg::BIAS_W-1:0] IF_LINEARIZER_BIAS,
  output logic [trim_regs_pkg::BIAS_W-1:0] IF_MAIN_BIAS,
  output logic [trim_regs_pkg::LPF_W-1:0] LOWPASS_TRIM,
  output trim_regs_pkg::synth_resets_s SYNTH_RESET_N
);

  // ==========================================================
  // Helpers
  function automatic logic [trim_regs_pkg::TRIM_W-1:0] pick_trim(
    input logic five,
    input logic hp,
    input logic [trim_regs_pkg::TRIM_W-1:0] lp3,
    input logic [trim_regs_pkg::TRIM_W-1:0] hp3,
    input logic [trim_regs_pkg::TRIM_W-1:0] lp5,
    input logic [trim_regs_pkg::TRIM_W-1:0] hp5
  );
    logic [trim_regs_pkg::TRIM_W-1:0] v;
    if (!five && !hp) begin
      v = lp3;
    end else if (!five && hp) begin
      v = hp3;
    end else if (five && !hp) begin
      v = lp5;
    end else begin
      v = hp5;
    end
    return v;
  endfunction

  function automatic logic [7:0] pad_trim(input logic [trim_regs_pkg::TRIM_W-1:0] t);
    return {3'h0, t};
  endfunction

  trim_regs_pkg::regs_s st_r;
  trim_regs_pkg::regs_s st_nxt;
  logic [trim_regs_pkg::TRIM_W-1:0] ch1_sel_w;
  logic [trim_regs_pkg::TRIM_W-1:0] ch2_sel_w;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    if (REG_WR) begin
      if (REG_ADDR == trim_regs_pkg::ADDR_CH1_LP3) begin
        st_nxt.ch1_lp3 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_HP3) begin
        st_nxt.ch1_hp3 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_LP5) begin
        st_nxt.ch1_lp5 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_HP5) begin
        st_nxt.ch1_hp5 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH2_LP3) begin
        st_nxt.ch2_lp3 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH2_HP3) begin
        st_nxt.ch2_hp3 = REG_WDATA[trim_regs_pkg::TRIM_W-1:0];
      end else if (REG_ADDR == trim_regs_pkg::ADDR_SRCSEL) begin
        st_nxt.srcsel = REG_WDATA;
      end else if (REG_ADDR == trim_regs_pkg::ADDR_BLKRST) begin
        st_nxt.blkrst = REG_WDATA;
      end
    end
    if (REG_RD) begin
      if (REG_ADDR == trim_regs_pkg::ADDR_CH1_LP3) begin
        st_nxt.rdata = pad_trim(st_r.ch1_lp3);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_HP3) begin
        st_nxt.rdata = pad_trim(st_r.ch1_hp3);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_LP5) begin
        st_nxt.rdata = pad_trim(st_r.ch1_lp5);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH1_HP5) begin
        st_nxt.rdata = pad_trim(st_r.ch1_hp5);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH2_LP3) begin
        st_nxt.rdata = pad_trim(st_r.ch2_lp3);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_CH2_HP3) begin
        st_nxt.rdata = pad_trim(st_r.ch2_hp3);
      end else if (REG_ADDR == trim_regs_pkg::ADDR_SRCSEL) begin
        st_nxt.rdata = st_r.srcsel;
      end else if (REG_ADDR == trim_regs_pkg::ADDR_BLKRST) begin
        st_nxt.rdata = st_r.blkrst;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    // Trim set chosen by supply and power mode
    ch1_sel_w = pick_trim(AMP_FIVE_VOLT_SELECT, AMP_HIGH_PERF_SELECT, st_nxt.ch1_lp3,
      st_nxt.ch1_hp3, st_nxt.ch1_lp5, st_nxt.ch1_hp5);
    ch2_sel_w = pick_trim(AMP_FIVE_VOLT_SELECT, AMP_HIGH_PERF_SELECT, st_nxt.ch2_lp3,
      st_nxt.ch2_hp3, CH2_TRIM_LOWPOW_5V, CH2_TRIM_HIGHPERF_5V);
    // Source selection, internal value when bit clear
    st_nxt.ch2_out = st_nxt.srcsel[trim_regs_pkg::SEL_CH2] ? ch2_sel_w
      : CH2_TRIM_INTERNAL;
    st_nxt.ch1_out = st_nxt.srcsel[trim_regs_pkg::SEL_CH1] ? ch1_sel_w
      : CH1_TRIM_INTERNAL;
    st_nxt.gate_out = st_nxt.srcsel[trim_regs_pkg::SEL_GATE] ? MIXER_GATE_OVERRIDE
      : MIXER_GATE_INTERNAL;
    st_nxt.lin_out = st_nxt.srcsel[trim_regs_pkg::SEL_IFLIN] ? IF_LIN_OVERRIDE
      : IF_LIN_INTERNAL;
    st_nxt.main_out = st_nxt.srcsel[trim_regs_pkg::SEL_IFMAIN] ? IF_MAIN_OVERRIDE
      : IF_MAIN_INTERNAL;
    st_nxt.lpf_out = st_nxt.srcsel[trim_regs_pkg::SEL_LPF] ? LOWPASS_OVERRIDE
      : LOWPASS_INTERNAL;
    // Sub-synth_subblock_resets, held while a bit is low
    st_nxt.rst_out.lock_detect_n = st_nxt.blkrst[trim_regs_pkg::RST_LKD];
    st_nxt.rst_out.autocal_n = st_nxt.blkrst[trim_regs_pkg::RST_AUTOCAL];
    st_nxt.rst_out.ref_div_n = st_nxt.blkrst[trim_regs_pkg::RST_RDIV];
    st_nxt.rst_out.feedback_div_n = st_nxt.blkrst[trim_regs_pkg::RST_FEEDBACK_DIVIDER]
      & st_nxt.blkrst[trim_regs_pkg::RST_OSTG] & st_nxt.blkrst[trim_regs_pkg::RST_CORE]
      & st_nxt.blkrst[trim_regs_pkg::RST_ALL];
    st_nxt.rst_out.outstage_n = st_nxt.blkrst[trim_regs_pkg::RST_OSTG]
      & st_nxt.blkrst[trim_regs_pkg::RST_CORE]
      & st_nxt.blkrst[trim_regs_pkg::RST_ALL];
    st_nxt.rst_out.core_n = st_nxt.blkrst[trim_regs_pkg::RST_CORE]
      & st_nxt.blkrst[trim_regs_pkg::RST_ALL];
    st_nxt.rst_out.refcnt_n = st_nxt.blkrst[trim_regs_pkg::RST_ALL];
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= trim_regs_pkg::REGS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign CH1_TRIM = st_r.ch1_out;
  assign CH2_TRIM = st_r.ch2_out;
  assign MIXER_GATE = st_r.gate_out;
  assign IF_LINEARIZER_BIAS = st_r.lin_out;
  assign IF_MAIN_BIAS = st_r.main_out;
  assign LOWPASS_TRIM = st_r.lpf_out;
  assign SYNTH_RESET_N = st_r.rst_out;

  // ==========================================================
  // Checks
  logic quiet_w;
  assign quiet_w = !REG_WR;

  ch1_lp3_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[4] && !AMP_FIVE_VOLT_SELECT && !AMP_HIGH_PERF_SELECT)
    |=> (CH1_TRIM == $past(st_r.ch1_lp3)))
    else $error("ch1 low power 3.3V trim not applied");

  ch1_hp3_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[4] && !AMP_FIVE_VOLT_SELECT && AMP_HIGH_PERF_SELECT)
    |=> (CH1_TRIM == $past(st_r.ch1_hp3)))
    else $error("ch1 high perf 3.3V trim not applied");

  ch1_lp5_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[4] && AMP_FIVE_VOLT_SELECT && !AMP_HIGH_PERF_SELECT)
    |=> (CH1_TRIM == $past(st_r.ch1_lp5)))
    else $error("ch1 low power 5V trim not applied");

  ch1_hp5_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[4] && AMP_FIVE_VOLT_SELECT && AMP_HIGH_PERF_SELECT)
    |=> (CH1_TRIM == $past(st_r.ch1_hp5)))
    else $error("ch1 high perf 5V trim not applied");

  ch2_3v3_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[5] && !AMP_FIVE_VOLT_SELECT)
    |=> (CH2_TRIM == ($past(AMP_HIGH_PERF_SELECT) ? $past(st_r.ch2_hp3)
      : $past(st_r.ch2_lp3))) [*1])
    else $error("ch2 3.3V trim not applied");

  trim_write_rb_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_WR && !REG_RD && REG_ADDR == trim_regs_pkg::ADDR_CH2_HP3)
    ##1 (REG_RD && !REG_WR && REG_ADDR == trim_regs_pkg::ADDR_CH2_HP3)
    |=> (REG_RDATA == {3'h0, $past(REG_WDATA[4:0], 2)}))
    else $error("ch2 high perf trim readback wrong");

  ch_internal_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && !st_r.srcsel[5] && !st_r.srcsel[4])
    |=> (CH2_TRIM == $past(CH2_TRIM_INTERNAL)) && (CH1_TRIM == $past(CH1_TRIM_INTERNAL)))
    else $error("channel trim not internal with select clear");

  analog_src_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    quiet_w |=> (MIXER_GATE == ($past(st_r.srcsel[3]) ? $past(MIXER_GATE_OVERRIDE)
      : $past(MIXER_GATE_INTERNAL)))
      && (LOWPASS_TRIM == ($past(st_r.srcsel[0]) ? $past(LOWPASS_OVERRIDE)
      : $past(LOWPASS_INTERNAL))))
    else $error("mixer gate or lowpass source wrong");

  if_src_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[2] && !st_r.srcsel[1])
    |=> (IF_LINEARIZER_BIAS == $past(IF_LIN_OVERRIDE))
      && (IF_MAIN_BIAS == $past(IF_MAIN_INTERNAL)))
    else $error("IF bias source wrong");

  modulator_rst_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    !st_r.blkrst[0] |-> !SYNTH_RESET_N.refcnt_n && !SYNTH_RESET_N.core_n
      && !SYNTH_RESET_N.outstage_n && !SYNTH_RESET_N.feedback_div_n)
    else $error("modulator reset not spread");

  blkrst_hold_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    $changed(st_r.blkrst) |-> $past(REG_WR && REG_ADDR == trim_regs_pkg::ADDR_BLKRST))
    else $error("block reset register changed without write");

  lock_autocal_rst_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_WR && REG_ADDR == trim_regs_pkg::ADDR_BLKRST)
    |=> (SYNTH_RESET_N.lock_detect_n == $past(REG_WDATA[trim_regs_pkg::RST_LKD]))
      && (SYNTH_RESET_N.autocal_n == $past(REG_WDATA[trim_regs_pkg::RST_AUTOCAL])))
    else $error("lock detect or autocal reset wrong");

  divider_rst_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_WR && REG_ADDR == trim_regs_pkg::ADDR_BLKRST)
    |=> (SYNTH_RESET_N.ref_div_n == $past(REG_WDATA[trim_regs_pkg::RST_RDIV]))
      && (SYNTH_RESET_N.feedback_div_n == ($past(REG_WDATA[trim_regs_pkg::RST_FEEDBACK_DIVIDER])
      && (&$past(REG_WDATA[2:0])))))
    else $error("divider reset wrong");

  outstage_rst_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_WR && REG_ADDR == trim_regs_pkg::ADDR_BLKRST)
    |=> (SYNTH_RESET_N.outstage_n == (&$past(REG_WDATA[2:0]))))
    else $error("modulator output stage reset wrong");

  core_rst_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_WR && REG_ADDR == trim_regs_pkg::ADDR_BLKRST)
    |=> (SYNTH_RESET_N.core_n == (&$past(REG_WDATA[1:0]))))
    else $error("modulator core reset wrong");

  trim_reserved_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (REG_RD && REG_ADDR >= trim_regs_pkg::ADDR_CH1_LP3
      && REG_ADDR <= trim_regs_pkg::ADDR_CH2_HP3)
    |=> (REG_RDATA[7:5] == 3'h0))
    else $error("trim register upper bits not zero");

  reset_value_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    $rose(NRST) |-> (st_r.blkrst == trim_regs_pkg::BLKRST_RESET)
      && (SYNTH_RESET_N == trim_regs_pkg::RESETS_RELEASED))
    else $error("synth_subblock_resets not released after reset");

  if_main_src_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[trim_regs_pkg::SEL_IFMAIN])
    |=> (IF_MAIN_BIAS == $past(IF_MAIN_OVERRIDE)))
    else $error("IF main bias override not applied");

  ch2_5v_use_a: assert property (
    @(posedge CLK) disable iff (!NRST)
    (quiet_w && st_r.srcsel[trim_regs_pkg::SEL_CH2] && AMP_FIVE_VOLT_SELECT)
    |=> (CH2_TRIM == $past(AMP_HIGH_PERF_SELECT ? CH2_TRIM_HIGHPERF_5V : CH2_TRIM_LOWPOW_5V)))
    else $error("ch2 5V trim input not applied");

endmodule

`default_nettype wire

// >>> hdl/trim_regs_pkg.sv
package trim_regs_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] ADDR_CH1_LP3 = 16'h0304;
  localparam logic [15:0] ADDR_CH1_HP3 = 16'h0305;
  localparam logic [15:0] ADDR_CH1_LP5 = 16'h0306;
  localparam logic [15:0] ADDR_CH1_HP5 = 16'h0307;
  localparam logic [15:0] ADDR_CH2_LP3 = 16'h0308;
  localparam logic [15:0] ADDR_CH2_HP3 = 16'h0309;
  localparam logic [15:0] ADDR_SRCSEL = 16'h0310;
  localparam logic [15:0] ADDR_BLKRST = 16'h1021;

  // ==========================================================
  // Field widths and positions
  localparam int TRIM_W = 5;
  localparam int GATE_W = 4;
  localparam int BIAS_W = 4;
  localparam int LPF_W = 7;
  localparam int SEL_CH2 = 5;
  localparam int SEL_CH1 = 4;
  localparam int SEL_GATE = 3;
  localparam int SEL_IFLIN = 2;
  localparam int SEL_IFMAIN = 1;
  localparam int SEL_LPF = 0;
  localparam int RST_LKD = 6;
  localparam int RST_AUTOCAL = 5;
  localparam int RST_FEEDBACK_DIVIDER = 4;
  localparam int RST_RDIV = 3;
  localparam int RST_OSTG = 2;
  localparam int RST_CORE = 1;
  localparam int RST_ALL = 0;

  // ==========================================================
  // Reset values
  localparam logic [TRIM_W-1:0] TRIM_RESET = 5'h10;
  localparam logic [7:0] SRCSEL_RESET = 8'h00;
  localparam logic [7:0] BLKRST_RESET = 8'hff;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic lock_detect_n;
    logic autocal_n;
    logic ref_div_n;
    logic feedback_div_n;
    logic outstage_n;
    logic core_n;
    logic refcnt_n;
  } synth_resets_s;

  typedef struct packed {
    logic [TRIM_W-1:0] ch1_lp3;
    logic [TRIM_W-1:0] ch1_hp3;
    logic [TRIM_W-1:0] ch1_lp5;
    logic [TRIM_W-1:0] ch1_hp5;
    logic [TRIM_W-1:0] ch2_lp3;
    logic [TRIM_W-1:0] ch2_hp3;
    logic [7:0] srcsel;
    logic [7:0] blkrst;
    logic [7:0] rdata;
    logic [TRIM_W-1:0] ch1_out;
    logic [TRIM_W-1:0] ch2_out;
    logic [GATE_W-1:0] gate_out;
    logic [BIAS_W-1:0] lin_out;
    logic [BIAS_W-1:0] main_out;
    logic [LPF_W-1:0] lpf_out;
    synth_resets_s rst_out;
  } regs_s;

  localparam synth_resets_s RESETS_RELEASED = 7'h7f;

  localparam regs_s REGS_RESET = '{
    ch1_lp3: TRIM_RESET, ch1_hp3: TRIM_RESET, ch1_lp5: TRIM_RESET,
    ch1_hp5: TRIM_RESET, ch2_lp3: TRIM_RESET, ch2_hp3: TRIM_RESET,
    srcsel: SRCSEL_RESET, blkrst: BLKRST_RESET, rdata: RDATA_RESET,
    ch1_out: '0, ch2_out: '0, gate_out: '0, lin_out: '0, main_out: '0,
    lpf_out: '0, rst_out: RESETS_RELEASED
  };

endpackage

// >>> sim/test_trim_override_and_block_reset_regs.sv
`timescale 1ns/100ps
`default_nettype none

module test_trim_override_and_block_reset_regs;
  // ==========================================================
  // Signals
  typedef struct {logic [7:0] exp; int sel;} note_s;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, five = 1'b0, hp = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata, d, pat;
  logic [4:0] ch1_int = '0, ch2_int = '0, ch2_lp5 = '0, ch2_hp5 = '0, ch1_out, ch2_out, e2;
  logic [3:0] gate_int = '0, gate_ovr = '0, lin_int = '0, lin_ovr = '0, main_int = '0;
  logic [3:0] main_ovr = '0, gate_out, lin_out, main_out;
  logic [6:0] lpf_int = '0, lpf_ovr = '0, lpf_out;
  trim_regs_pkg::synth_resets_s rst_out;
  logic rd_d1 = 1'b0, rd_d2 = 1'b0, obs = 1'b0, obs_d = 1'b0;
  int err_count = 0, n_tests = 0;
  logic [31:0] seed = 32'h0000004b, v;
  logic [4:0] tv[6];
  note_s notes[$];
  string names[8] = '{"rdata", "ch1_trim", "ch2_trim", "mixer_gate", "if_lin", "if_main",
    "lowpass", "resets"};
  logic [15:0] tr_addr[6] = '{trim_regs_pkg::ADDR_CH1_LP3, trim_regs_pkg::ADDR_CH1_HP3,
    trim_regs_pkg::ADDR_CH1_LP5, trim_regs_pkg::ADDR_CH1_HP5, trim_regs_pkg::ADDR_CH2_LP3,
    trim_regs_pkg::ADDR_CH2_HP3};

  always #20 clk = ~clk;

  trim_override_and_block_reset_regs trim_override_and_block_reset_regs_inst (
    .CLK(clk), .NRST(nrst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .AMP_FIVE_VOLT_SELECT(five), .AMP_HIGH_PERF_SELECT(hp),
    .CH1_TRIM_INTERNAL(ch1_int), .CH2_TRIM_INTERNAL(ch2_int), .CH2_TRIM_LOWPOW_5V(ch2_lp5),
    .CH2_TRIM_HIGHPERF_5V(ch2_hp5), .MIXER_GATE_INTERNAL(gate_int),
    .MIXER_GATE_OVERRIDE(gate_ovr), .IF_LIN_INTERNAL(lin_int), .IF_LIN_OVERRIDE(lin_ovr),
    .IF_MAIN_INTERNAL(main_int), .IF_MAIN_OVERRIDE(main_ovr), .LOWPASS_INTERNAL(lpf_int),
    .LOWPASS_OVERRIDE(lpf_ovr), .CH1_TRIM(ch1_out), .CH2_TRIM(ch2_out), .MIXER_GATE(gate_out),
    .IF_LINEARIZER_BIAS(lin_out), .IF_MAIN_BIAS(main_out), .LOWPASS_TRIM(lpf_out),
    .SYNTH_RESET_N(rst_out)
  );

  // ==========================================================
  // Helpers
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [6:0] exp_rst(input logic [7:0] b);
    return {b[6], b[5], b[3], &{b[4], b[2], b[1], b[0]}, &b[2:0], &b[1:0], b[0]};
  endfunction

  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task note(input int s, input logic [7:0] e);
    note_s n;
    n.exp = e;
    n.sel = s;
    notes.push_back(n);
  endtask

  task wr_reg(input logic [15:0] a, input logic [7:0] dat);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = dat;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task rd_reg(input logic [15:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    note(0, e);
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask

  task chk_out(input int s, input logic [7:0] e);
    repeat (2) @(negedge clk);
    obs = 1'b1;
    note(s, e);
    @(negedge clk);
    obs = 1'b0;
  endtask

  task randin;
    v = rnd();
    {lin_int, gate_ovr, gate_int, ch2_hp5, ch2_lp5, ch2_int, ch1_int} = v;
    v = rnd();
    {lpf_ovr, lpf_int, main_ovr, main_int, lin_ovr} = v[25:0];
  endtask

  // ==========================================================
  // Monitor
  always @(posedge clk) begin
    rd_d1 <= rd;
    rd_d2 <= rd_d1;
    obs_d <= obs;
  end

  always @(negedge clk) begin
    note_s n;
    logic [7:0] seen;
    if (rd_d2 || obs_d) begin
      if (notes.size() == 0) begin
        err_count++;
        $display("BAD queue expected note seen none");
      end else begin
        n = notes.pop_front();
        case (n.sel)
          0: seen = rdata;
          1: seen = {3'h0, ch1_out};
          2: seen = {3'h0, ch2_out};
          3: seen = {4'h0, gate_out};
          4: seen = {4'h0, lin_out};
          5: seen = {4'h0, main_out};
          6: seen = {1'b0, lpf_out};
          default: seen = {1'b0, rst_out};
        endcase
        check(names[n.sel], seen, n.exp);
      end
    end
  end

  // ==========================================================
  // Stimulus
  initial begin
    #800000;
    err_count++;
    report_and_stop;
  end

  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    randin;
    for (int i = 0; i < 6; i++) rd_reg(tr_addr[i], 8'h10);
    rd_reg(trim_regs_pkg::ADDR_SRCSEL, 8'h00);
    rd_reg(trim_regs_pkg::ADDR_BLKRST, 8'hff);
    rd_reg(16'h0311, 8'h00);
    chk_out(7, 8'h7f);
    chk_out(1, {3'h0, ch1_int});
    chk_out(2, {3'h0, ch2_int});
    chk_out(3, {4'h0, gate_int});
    chk_out(6, {1'b0, lpf_int});
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      d = v[7:0] | 8'he0;
      tv[i] = d[4:0];
      wr_reg(tr_addr[i], d);
      rd_reg(tr_addr[i], {3'h0, d[4:0]});
    end
    wr_reg(trim_regs_pkg::ADDR_SRCSEL, 8'h30);
    for (int m = 0; m < 4; m++) begin
      {five, hp} = m[1:0];
      e2 = (m == 0) ? tv[4] : (m == 1) ? tv[5] : (m == 2) ? ch2_lp5 : ch2_hp5;
      chk_out(1, {3'h0, tv[m]});
      chk_out(2, {3'h0, e2});
    end
    $display("test trim selection done");
    randin;
    wr_reg(trim_regs_pkg::ADDR_SRCSEL, 8'hcf);
    rd_reg(trim_regs_pkg::ADDR_SRCSEL, 8'hcf);
    chk_out(1, {3'h0, ch1_int});
    chk_out(3, {4'h0, gate_ovr});
    chk_out(4, {4'h0, lin_ovr});
    chk_out(5, {4'h0, main_ovr});
    chk_out(6, {1'b0, lpf_ovr});
    wr_reg(trim_regs_pkg::ADDR_SRCSEL, 8'h00);
    chk_out(4, {4'h0, lin_int});
    chk_out(5, {4'h0, main_int});
    $display("test override select done");
    for (int i = 0; i < 8; i++) begin
      pat = ~(8'h01 << i);
      wr_reg(trim_regs_pkg::ADDR_BLKRST, pat);
      chk_out(7, {1'b0, exp_rst(pat)});
      rd_reg(trim_regs_pkg::ADDR_BLKRST, pat);
    end
    wr_reg(trim_regs_pkg::ADDR_BLKRST, 8'hff);
    chk_out(7, 8'h7f);
    $display("test synth_subblock_resets done");
    wr_reg(trim_regs_pkg::ADDR_SRCSEL, 8'h3f);
    wr_reg(trim_regs_pkg::ADDR_BLKRST, 8'h00);
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    rd_reg(trim_regs_pkg::ADDR_SRCSEL, 8'h00);
    rd_reg(trim_regs_pkg::ADDR_BLKRST, 8'hff);
    rd_reg(tr_addr[0], 8'h10);
    chk_out(7, 8'h7f);
    chk_out(1, {3'h0, ch1_int});
    $display("test mid-run reset done");
    for (int k = 0; k < 10 && notes.size() > 0; k++) @(negedge clk);
    if (notes.size() > 0) err_count++;
    report_and_stop;
  end
endmodule

`default_nettype wire
